// file: verification/ipd_asserts.sv
// ipd_asserts: checks on the serial link and the core outputs
// assumes one clk domain; instantiated by the bench beside the link interface
`timescale 1ns/1ps
`default_nettype none
module ipd_asserts
  import ipd_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        sck,
  input wire logic        sdata,
  input wire logic        load_strobe,
  input wire logic        chip_en,
  input wire logic        pump_up,
  input wire logic        pump_output,
  input wire logic        pump_output_oe,
  input wire logic        powered_down,
  input wire logic        rf_input_en,
  input wire logic        ref_osc_en,
  input wire logic [16:0] ref_word,
  input wire logic [16:0] fb_word
);
  logic [17:0] sh_reg;
  logic [4:0]  bit_cnt_reg;
  logic        sck_q_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // shadow shift register, sampled once per clk as the core does
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_reg <= 18'h0_0000;
      bit_cnt_reg <= 5'h00;
      sck_q_reg <= 1'b0;
    end else begin
      sck_q_reg <= sck;
      if (load_strobe) begin
        bit_cnt_reg <= 5'h00;
      end else if (sck && !sck_q_reg) begin
        sh_reg <= {sh_reg[16:0], sdata};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end
  word_len_a: assert property ($rose(load_strobe) |-> bit_cnt_reg == 5'd18)
    else $error("load strobe without 18 serial bits");
  latch_load_a: assert property ($rose(load_strobe) |-> ##[1:4]
    ((sh_reg[0] ? ref_word : fb_word) == sh_reg[17:1])) else $error("latch not loaded");
  // strobe stands SCK_HALF_CYC+1 cycles, which keeps it above the minimum enable width
  strobe_pulse_a: assert property ($rose(load_strobe) |-> load_strobe[*3] ##1 !load_strobe)
    else $error("load strobe width wrong");
  data_setup_a: assert property ($rose(sck) |-> $stable(sdata))
    else $error("data moved at clock rise");
  ce_down_a: assert property (!chip_en |-> powered_down)
    else $error("chip enable low but running");
  pd_quiet_a: assert property (powered_down |-> !pump_output_oe && !pump_up)
    else $error("pump active in power down");
  power_down_bit_inputs_a: assert property (chip_en && fb_word[POWER_DOWN_BIT_POS-1] |->
    !rf_input_en && !ref_osc_en) else $error("inputs on while powered down");
  pump_tri_a: assert property (ref_word[TRI_POS-1] && !ref_word[TEST_POS-1] |->
    !pump_output_oe) else $error("pump driven while disabled");
  pump_dir_a: assert property (pump_output_oe && !ref_word[TEST_POS-1] |->
    pump_output == pump_up) else $error("pump level wrong");
  cover property ($rose(load_strobe) && sh_reg[0]);
  cover property ($rose(load_strobe) && !sh_reg[0]);
  cover property (pump_up && pump_output_oe);
  cover property (powered_down && chip_en);
endmodule
`default_nettype wire

// file: verification/ipd_core_tb.sv
// ipd_core_tb: host and core joined by the link, driven over apb
// assumes the rf input toggles only from the feedback scenario on
`timescale 1ns/1ps
`default_nettype none
module ipd_core_tb;
  import ipd_pkg::*;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ref_in;
  logic        ref_run;
  logic        rf_pos;
  logic        rf_neg;
  logic        rf_run;
  logic        pump_up;
  logic        pump_down;
  logic        pump_output;
  logic        pump_output_oe;
  logic        rf_input_en;
  logic        ref_osc_en;
  logic        powered_down;
  logic [16:0] ref_word;
  logic [16:0] fb_word;
  int          error_cnt;
  int          samples_checked;
  int          cyc;
  ipd_link_if link_if ();
  ipd_host ipd_host_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  ipd_core ipd_core_i (.clk(clk), .nrst(nrst), .link(link_if), .ref_osc_input(ref_in),
    .rf_input_pos(rf_pos), .rf_input_neg(rf_neg), .pump_up(pump_up), .pump_down(pump_down),
    .pump_output(pump_output), .pump_output_oe(pump_output_oe), .rf_input_en(rf_input_en),
    .ref_osc_en(ref_osc_en), .powered_down(powered_down), .ref_word(ref_word),
    .fb_word(fb_word));
  ipd_asserts ipd_asserts_i (.clk(clk), .nrst(nrst), .sck(link_if.sck),
    .sdata(link_if.sdata), .load_strobe(link_if.load_strobe), .chip_en(link_if.chip_en),
    .pump_up(pump_up), .pump_output(pump_output), .pump_output_oe(pump_output_oe),
    .powered_down(powered_down), .rf_input_en(rf_input_en), .ref_osc_en(ref_osc_en),
    .ref_word(ref_word), .fb_word(fb_word));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (ref_run) begin
      ref_in <= ~ref_in;
    end
    if (rf_run) begin
      rf_pos <= ~rf_pos;
      rf_neg <= rf_pos;
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang here would otherwise run forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // waits an edge first so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [17:0] w);
    logic [31:0] rd;
    logic        e;
    int          i;
    apb(1'b1, 8'h00, 32'(w), rd, e);
    rd = 32'h0000_0002;
    i = 0;
    while (rd[1] !== 1'b0 && i < 200) begin
      apb(1'b0, 8'h04, 32'h0000_0000, rd, e);
      i++;
    end
    repeat (2) @(posedge clk);
    chk("latch", 32'(w[17:1]), 32'(w[0] ? ref_word : fb_word));
  endtask
  // spacing in clk cycles between pump_output pulses, sampled mid-cycle
  task automatic period(input string n, input int e);
    int c;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (pump_output !== 1'b1 && c < 2200);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (pump_output !== 1'b1 && c < 2200);
    chk(n, 32'(e), 32'(c));
  endtask
  function automatic logic [17:0] rw(input logic [9:0] r, input logic t, input logic p,
                                     input logic x);
    return {3'b000, x, 1'b0, p, t, r, 1'b1};
  endfunction
  task automatic t_basic();
    logic [31:0] rd;
    logic        e;
    chk("ref reset", 32'(REF_RST), 32'(ref_word));
    chk("fb reset", 32'(FB_RST), 32'(fb_word));
    chk("down", 32'h0000_0001, 32'(powered_down));
    apb(1'b1, 8'h04, 32'h0000_0001, rd, e);
    apb(1'b0, 8'h04, 32'h0000_0000, rd, e);
    chk("ce bit", 32'h0000_0001, 32'(rd[0]));
    apb(1'b0, 8'h08, 32'h0000_0000, rd, e);
    chk("slverr", 32'h0000_0001, 32'(e));
  endtask
  task automatic t_pump();
    send(rw(10'd1023, 1'b0, 1'b1, 1'b0));
    send({10'd31, 5'd0, 3'b000});
    send(rw(10'd2, 1'b0, 1'b1, 1'b0));
    // ref at half of clk over ratio two keeps the detector rate low
    ref_run <= 1'b1;
    repeat (30) @(posedge clk);
    chk("up", 32'h0000_0001, 32'(pump_up && pump_output_oe && pump_output));
    send(rw(10'd2, 1'b0, 1'b0, 1'b0));
    repeat (4) @(posedge clk);
    chk("dn", 32'h0000_0001, 32'(pump_down && pump_output_oe && !pump_output));
    send(rw(10'd2, 1'b1, 1'b0, 1'b0));
    chk("tri", 32'h0000_0000, 32'(pump_output_oe));
  endtask
  task automatic t_test();
    int n;
    logic last;
    send(rw(10'd2, 1'b1, 1'b0, 1'b1));
    period("ref period", 2 * 2);
    n = 0;
    last = pump_output;
    repeat (40) begin
      @(negedge clk);
      if (pump_output !== last) n++;
      last = pump_output;
    end
    chk("test oe", 32'h0000_0001, 32'(pump_output_oe));
    chk("test out", 32'h0000_0001, 32'(n > 4));
    send(rw(10'd1023, 1'b1, 1'b0, 1'b1));
    period("ref 1023", 2 * 1023);
  endtask
  task automatic t_fb();
    send({10'd31, 5'd3, 3'b000});
    rf_run <= 1'b1;
    send(rw(10'd2, 1'b1, 1'b1, 1'b1));
    period("fb period", 2 * (PRE_DIV * 31 + 3));
  endtask
  task automatic t_down();
    logic [31:0] rd;
    logic        e;
    send({10'd40, 5'd3, 3'b100});
    chk("power_down_bit", 32'h0000_0001, 32'(powered_down && !rf_input_en && !ref_osc_en));
    chk("power_down_bit oe", 32'h0000_0000, 32'(pump_output_oe));
    apb(1'b1, 8'h04, 32'h0000_0000, rd, e);
    send({10'd40, 5'd3, 3'b000});
    send(rw(10'd5, 1'b0, 1'b1, 1'b0));
    chk("ce down", 32'h0000_0001, 32'(powered_down));
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ref_in = 1'b0;
    ref_run = 1'b0;
    rf_pos = 1'b0;
    rf_neg = 1'b1;
    rf_run = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_basic();
    t_pump();
    t_test();
    t_fb();
    t_down();
    results();
  end
endmodule
`default_nettype wire

// file: verilog/ipd_core.sv
// ipd_core: digital core of an integer-n synthesizer (serial port, dividers, detector, pump)
// assumes ref/rf inputs are levels synchronous to clk; the core edge-detects them into one-cycle enables
// Functional notes
// [RULE1] reference divider 10 bits, ratio 2..1023
// [RULE2] reference divider clocked from oscillator input
// [RULE3] feedback: 5-bit swallow, 10-bit main counter
// [RULE4] prescaler divides by 32 or 33
// [RULE5] detector compares both dividers, drives pump
// [RULE6] polarity bit swaps up and down
// [RULE7] pump up, down, else high impedance
// [RULE8] host keeps detector rate at 10 MHz max
// [RULE9] shift data on serial clock rising edge
// [RULE10] host sends msb first, address last
// [RULE11] last bit selects destination latch
// [RULE12] load strobe rise copies word into latch
// [RULE13] chip enable low forces power down
// [RULE14] power-down bit stops dividers and inputs
// [RULE15] power down tristates pump and detector
// [RULE16] power down resets both dividers
// [RULE17] restart feedback aligned to reference
// [RULE18] serial port works during power down
// [RULE19] address 1 reference, 0 feedback register
// [RULE20] pump disable bit tristates pump, detector; with the test bit also set the code still drives the pump from a divider
// [RULE21] polarity clear means negative vco slope
// [RULE22] test bit routes a divider to pump
// [RULE23] ratio is 32 times main plus swallow
`timescale 1ns/1ps
`default_nettype none
module ipd_core
  import ipd_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  ipd_link_if.dev   link,
  input  wire logic ref_osc_input,
  input  wire logic rf_input_pos,
  input  wire logic rf_input_neg,
  output logic      pump_up,
  output logic      pump_down,
  output logic      pump_output,
  output logic      pump_output_oe,
  output logic      rf_input_en,
  output logic      ref_osc_en,
  output logic      powered_down,
  output logic [16:0] ref_word,
  output logic [16:0] fb_word
);
  import ipd_pkg::*;
  logic [WORD_W-1:0] shift_reg;
  logic              sck_d_reg;
  logic              ls_d_reg;
  logic              ref_d_reg;
  logic              rf_d_reg;
  logic              pd;
  logic              ref_edge;
  logic              rf_edge;
  logic              pre_tick;
  logic              ref_tick;
  logic              fb_tick;
  logic [5:0]        pre_cnt_reg;
  logic              swal_done_reg;
  logic [SWAL_W-1:0] swal_cnt_reg;
  logic [MAIN_W-1:0] main_cnt_reg;
  logic              up_reg;
  logic              dn_reg;
  logic              hold_reg;
  logic              tri_mode;
  logic              test_on;
  logic              pol;

  // serial port never gated by power down [RULE18]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_d_reg <= 1'b0;
      ls_d_reg  <= 1'b0;
      shift_reg <= '0;
    end else begin
      sck_d_reg <= link.sck;
      ls_d_reg  <= link.load_strobe;
      if (link.sck && !sck_d_reg) begin
        shift_reg <= {shift_reg[WORD_W-2:0], link.sdata}; // [RULE9]
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_word <= REF_RST;
      fb_word  <= FB_RST;
    end else if (link.load_strobe && !ls_d_reg) begin // [RULE12]
      if (shift_reg[ADDR_POS]) begin // [RULE11] [RULE19]
        ref_word <= shift_reg[WORD_W-1:1];
      end else begin
        fb_word <= shift_reg[WORD_W-1:1];
      end
    end
  end

  // chip enable acts without the clock; the bit path is registered [RULE13] [RULE14]
  assign pd           = !link.chip_en || fb_word[POWER_DOWN_BIT_POS-1];
  assign powered_down = pd;
  assign rf_input_en  = !pd;
  assign ref_osc_en   = !pd;

  // inputs treated as synchronous; edge detect turns them into enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_d_reg <= 1'b0;
      rf_d_reg  <= 1'b0;
    end else begin
      ref_d_reg <= ref_osc_input;
      rf_d_reg  <= rf_input_pos && !rf_input_neg;
    end
  end
  assign ref_edge = ref_osc_input && !ref_d_reg && !pd; // [RULE2]
  assign rf_edge  = rf_input_pos && !rf_input_neg && !rf_d_reg && !pd;

  // reference divider; ratios below two are held at two [RULE1]
  ipd_prog_div #(.W(REF_CNT_W)) u_ref_div (
    .clk   (clk),
    .nrst  (nrst),
    .clr   (pd), // [RULE16]
    .en    (ref_edge),
    .ratio ((ref_word[REF_CNT_LSB-1 +: REF_CNT_W] < REF_CNT_W'(REF_MIN)) ?
            REF_CNT_W'(REF_MIN) : ref_word[REF_CNT_LSB-1 +: REF_CNT_W]),
    .tick  (ref_tick)
  );

  // dual-modulus prescaler: 33 while swallowing, else 32 [RULE4]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_reg <= '0;
      pre_tick    <= 1'b0;
    end else if (pd) begin
      pre_cnt_reg <= '0;
      pre_tick    <= 1'b0;
    end else begin
      pre_tick <= 1'b0;
      if (rf_edge && !hold_reg) begin
        // one extra rf cycle per output while swallowing
        if (pre_cnt_reg >= (swal_done_reg ? 6'(PRE_DIV - 1) : 6'(PRE_DIV))) begin
          pre_cnt_reg <= '0;
          pre_tick    <= 1'b1;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 6'h01;
        end
      end
    end
  end

  // swallow and main counters; main must be >= swallow [RULE3] [RULE23]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swal_cnt_reg  <= '0;
      main_cnt_reg  <= '0;
      swal_done_reg <= 1'b0;
      hold_reg      <= 1'b1;
      fb_tick       <= 1'b0;
    end else if (pd) begin // [RULE16]
      swal_cnt_reg  <= '0;
      main_cnt_reg  <= '0;
      swal_done_reg <= (fb_word[SWAL_LSB-1 +: SWAL_W] == '0);
      hold_reg      <= 1'b1;
      fb_tick       <= 1'b0;
    end else begin
      fb_tick <= 1'b0;
      // rf counting waits for the first reference edge, the one that also starts
      // the reference divider, so both restart within one rf cycle [RULE17]
      if (hold_reg && ref_edge) begin
        hold_reg <= 1'b0;
      end
      if (pre_tick) begin
        if (swal_cnt_reg + 5'h1 >= fb_word[SWAL_LSB-1 +: SWAL_W]) begin
          swal_done_reg <= 1'b1;
        end
        swal_cnt_reg <= swal_cnt_reg + 5'h1;
        if (main_cnt_reg + MAIN_W'(1) >= fb_word[MAIN_LSB-1 +: MAIN_W]) begin
          main_cnt_reg  <= '0;
          swal_cnt_reg  <= '0;
          swal_done_reg <= (fb_word[SWAL_LSB-1 +: SWAL_W] == '0);
          fb_tick       <= 1'b1;
        end else begin
          main_cnt_reg <= main_cnt_reg + MAIN_W'(1);
        end
      end
    end
  end

  assign test_on  = ref_word[TEST_POS-1];
  assign tri_mode = ref_word[TRI_POS-1];
  assign pol      = ref_word[POL_POS-1];

  // phase/frequency detector: set on own edge, clear when both seen [RULE5]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else if (pd || tri_mode) begin // [RULE15] [RULE20]
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      if ((up_reg || ref_tick) && (dn_reg || fb_tick)) begin
        up_reg <= 1'b0;
        dn_reg <= 1'b0;
      end else begin
        up_reg <= up_reg || ref_tick;
        dn_reg <= dn_reg || fb_tick;
      end
    end
  end

  // positive slope: ref ahead pumps up; negative slope swaps [RULE6] [RULE21]
  always_comb begin
    pump_up        = 1'b0;
    pump_down      = 1'b0;
    pump_output    = 1'b0;
    pump_output_oe = 1'b0;
    if (pd) begin
      pump_output_oe = 1'b0; // [RULE13] [RULE15]
    end else if (test_on) begin
      pump_output_oe = 1'b1; // [RULE22]
      pump_output    = pol ? fb_tick : ref_tick;
    end else if (!tri_mode) begin
      pump_up   = pol ? up_reg : dn_reg;
      pump_down = pol ? dn_reg : up_reg;
      pump_output_oe = pump_up ^ pump_down; // [RULE7]
      pump_output    = pump_up;
    end
  end
endmodule
`default_nettype wire

// file: verilog/ipd_host.sv
// ipd_host: apb slave that shifts 18-bit words out on the serial port
// assumes the core samples sck once per clk
`timescale 1ns/1ps
`default_nettype none
module ipd_host
  import ipd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  ipd_link_if.host         link
);
  import ipd_pkg::*;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b11, H_LOAD = 2'b10} ipd_hst_t;
  ipd_hst_t          st_reg;
  logic [WORD_W-1:0] word_reg;
  logic [4:0]        bit_reg;
  logic [7:0]        tmr_reg;
  logic              ce_reg;
  logic              wr;
  // word at 0x00 starts a transfer; 0x04 bit0 chip enable, bit1 busy
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != 8'h00) && (paddr != 8'h04);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (paddr == 8'h04) ? {30'h0, (st_reg != H_IDLE), ce_reg} : 32'h0000_0000;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_reg <= 1'b0;
    end else if (wr && paddr == 8'h04) begin
      ce_reg <= pwdata[0];
    end
  end
  // writes while busy are dropped: software polls busy first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg   <= H_IDLE;
      word_reg <= '0;
      bit_reg  <= '0;
      tmr_reg  <= '0;
    end else begin
      if (tmr_reg != 8'h0) begin
        tmr_reg <= tmr_reg - 8'h1;
      end else begin
        unique case (st_reg)
          H_IDLE: if (wr && paddr == 8'h00) begin
            word_reg <= pwdata[WORD_W-1:0];
            bit_reg  <= 5'(WORD_W);
            st_reg   <= H_LOW;
            tmr_reg  <= 8'(SCK_HALF_CYC);
          end
          H_LOW: begin
            st_reg  <= H_HIGH; // msb first, address last [RULE10]
            tmr_reg <= 8'(SCK_HALF_CYC);
          end
          H_HIGH: begin
            word_reg <= {word_reg[WORD_W-2:0], 1'b0};
            bit_reg  <= bit_reg - 5'h1;
            st_reg   <= (bit_reg == 5'h1) ? H_LOAD : H_LOW;
            tmr_reg  <= 8'(SCK_HALF_CYC);
          end
          H_LOAD: st_reg <= H_IDLE; // strobe after final bit [RULE12]
        endcase
      end
    end
  end
  assign link.sck         = (st_reg == H_HIGH);
  assign link.sdata       = word_reg[WORD_W-1];
  assign link.load_strobe = (st_reg == H_LOAD);
  assign link.chip_en     = ce_reg;
endmodule
`default_nettype wire

// file: verilog/ipd_link_if.sv
// ipd_link_if: three-wire serial port plus chip enable between host and core
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface ipd_link_if;
  logic sck;
  logic sdata;
  logic load_strobe;
  logic chip_en;
  modport host (output sck, output sdata, output load_strobe, output chip_en);
  modport dev  (input sck, input sdata, input load_strobe, input chip_en);
endinterface
`default_nettype wire

// file: verilog/ipd_pkg.sv
// ipd_pkg: constants shared by the synthesizer core and its serial host
// assumes a single 25 MHz system clock; ref and rf inputs are sampled as enables
package ipd_pkg;
  localparam int WORD_W        = 18;
  localparam int ADDR_POS      = 0;
  localparam int REF_CNT_LSB   = 1;
  localparam int REF_CNT_W     = 10;
  localparam int POL_POS       = 12;
  localparam int TRI_POS       = 11;
  localparam int TEST_POS      = 14;
  localparam int SWAL_LSB      = 3;
  localparam int SWAL_W        = 5;
  localparam int MAIN_LSB      = 8;
  localparam int MAIN_W        = 10;
  localparam int POWER_DOWN_BIT_POS      = 2;
  localparam int PRE_DIV       = 32;
  localparam int REF_MIN       = 2;
  localparam logic [16:0] REF_RST = 17'h0_0002;
  localparam logic [16:0] FB_RST  = 17'h0_0004;
  localparam int CLK_HZ        = 25_000_000;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [1:0] {PUMP_OFF = 2'b00, PUMP_UP = 2'b01, PUMP_DN = 2'b10} ipd_pump_t;
endpackage

// file: verilog/ipd_prog_div.sv
// ipd_prog_div: programmable divider counting input enables, one pulse per wrap
// assumes en pulses are one clk wide
`timescale 1ns/1ps
`default_nettype none
module ipd_prog_div #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);
  logic [W-1:0] cnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if (clr) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        if (cnt_reg >= ratio - W'(1)) begin
          cnt_reg <= '0;
          tick    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire
